// File: include/gio_pkg.sv
// Summary of operation
// - port7 latch drives pin in output mode
// - port7 direction: 0 input, 1 output
// - port7 select: latch or divider/pulse output
// - port7 pin read: level if input, else 0
// - port8 two pins, own direction each
// - port8 direction: 0 input, 1 output
// - port8 select: latch or pulse channel
// - port8 pin read: level if input, else 0
// - port8 latch drives pins, resets to zero
// - port9 two pins shared with second uart
// - port9 per pin open-drain or push-pull
// - port9 pull-up only input or open-drain
// - port9 high: driven, or released in open-drain
// - port9 direction: 0 receive input, 1 output
// - port7 per bit direction, shared functions
// - port9 drive type: 0 cmos, 1 open-drain
// - port9 select: latch or uart transmit
// - port9 pin read: level unless cmos output
package gio_pkg;

  // ****************************************************
  // register indices, byte address is four times these
  // ****************************************************
  localparam int GIO_ADDR_W = 14;
  localparam logic [11:0] GIO_IDX_P7_LATCH = 12'h007;
  localparam logic [11:0] GIO_IDX_P8_LATCH = 12'h008;
  localparam logic [11:0] GIO_IDX_P9_LATCH = 12'h009;
  localparam logic [11:0] GIO_IDX_P7_PIN = 12'h014;
  localparam logic [11:0] GIO_IDX_P8_PIN = 12'h015;
  localparam logic [11:0] GIO_IDX_P9_PIN = 12'h016;
  localparam logic [11:0] GIO_IDX_P7_DIR = 12'hF21;
  localparam logic [11:0] GIO_IDX_P8_DIR = 12'hF22;
  localparam logic [11:0] GIO_IDX_P9_DIR = 12'hF23;
  localparam logic [11:0] GIO_IDX_P7_ALT = 12'hF3B;
  localparam logic [11:0] GIO_IDX_P8_ALT = 12'hF3C;
  localparam logic [11:0] GIO_IDX_P9_ALT = 12'hF3D;
  localparam logic [11:0] GIO_IDX_P9_PULLUP = 12'hF30;
  localparam logic [11:0] GIO_IDX_P9_DRIVE = 12'hF4A;

  // ****************************************************
  // field positions and widths
  // ****************************************************
  localparam int GIO_P7_W = 8;
  localparam int GIO_P7_ALT_W = 5;
  localparam int GIO_P2_W = 2;
  localparam logic [7:0] GIO_P7_IN_FUNC_MASK = 8'hEF;
  localparam logic [31:0] GIO_RESET_WORD = 32'h0000_0000;

  // ****************************************************
  // whole state of the block
  // ****************************************************
  typedef struct packed {
    logic [7:0] p7_latch;
    logic [7:0] p7_dir;
    logic [4:0] p7_alt;
    logic [1:0] p8_latch;
    logic [1:0] p8_dir;
    logic [1:0] p8_alt;
    logic [1:0] p9_latch;
    logic [1:0] p9_dir;
    logic [1:0] p9_alt;
    logic [1:0] p9_drive;
    logic [1:0] p9_pullup;
    logic [7:0] p7_sync1;
    logic [7:0] p7_sync2;
    logic [1:0] p8_sync1;
    logic [1:0] p8_sync2;
    logic [1:0] p9_sync1;
    logic [1:0] p9_sync2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] p7_out;
    logic [7:0] p7_oe;
    logic [1:0] p8_out;
    logic [1:0] p8_oe;
    logic [1:0] p9_out;
    logic [1:0] p9_oe;
    logic [1:0] p9_pull_on;
    logic [7:0] p7_func_in;
    logic [1:0] p8_func_in;
    logic [1:0] p9_rx_in;
  } gio_state_t;

  localparam gio_state_t GIO_STATE_RESET = '0;

endpackage

// File: hdl/gio_top.sv
module gio_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [gio_pkg::GIO_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  input wire logic [7:0] I_P7_PIN,
  output logic [7:0] O_P7_OUT,
  output logic [7:0] O_P7_OE,
  input wire logic [1:0] I_P8_PIN,
  output logic [1:0] O_P8_OUT,
  output logic [1:0] O_P8_OE,
  input wire logic [1:0] I_P9_PIN,
  output logic [1:0] O_P9_OUT,
  output logic [1:0] O_P9_OE,
  output logic [1:0] O_P9_PULLUP_ON,
  input wire logic [4:0] I_P7_PERIPH_OUT,
  input wire logic [1:0] I_P8_PERIPH_OUT,
  input wire logic I_SECOND_UART_TRANSMIT,
  output logic [7:0] O_P7_FUNC_IN,
  output logic [1:0] O_P8_FUNC_IN,
  output logic [1:0] O_SECOND_UART_RECEIVE
);
  import gio_pkg::*;

  gio_state_t st_q;
  gio_state_t st_d;
  logic [11:0] idx;
  logic wr_en;
  logic rd_phase;
  logic [7:0] p7_val;
  logic [1:0] p8_val;
  logic [1:0] p9_val;

  // ****************************************************
  // bus decode
  // ****************************************************
  // byte lanes 1:0 are ignored, registers sit on word boundaries
  assign idx = I_PADDR[GIO_ADDR_W-1:2];
  // write commits only on the edge where the master sees pready
  assign wr_en = I_PSEL & I_PENABLE & st_q.pready & I_PWRITE;
  assign rd_phase = I_PSEL & I_PENABLE & ~st_q.pready;

  function automatic logic mapped(input logic [11:0] a);
    case (a)
      GIO_IDX_P7_LATCH, GIO_IDX_P8_LATCH, GIO_IDX_P9_LATCH,
      GIO_IDX_P7_PIN, GIO_IDX_P8_PIN, GIO_IDX_P9_PIN,
      GIO_IDX_P7_DIR, GIO_IDX_P8_DIR, GIO_IDX_P9_DIR,
      GIO_IDX_P7_ALT, GIO_IDX_P8_ALT, GIO_IDX_P9_ALT,
      GIO_IDX_P9_PULLUP, GIO_IDX_P9_DRIVE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    st_d = st_q;

    // two-stage synchronisers on the pad inputs
    st_d.p7_sync1 = I_P7_PIN;
    st_d.p7_sync2 = st_q.p7_sync1;
    st_d.p8_sync1 = I_P8_PIN;
    st_d.p8_sync2 = st_q.p8_sync1;
    st_d.p9_sync1 = I_P9_PIN;
    st_d.p9_sync2 = st_q.p9_sync1;

    // register writes, unimplemented bits never stored
    if (wr_en) begin
      case (idx)
        GIO_IDX_P7_LATCH: st_d.p7_latch = I_PWDATA[7:0];
        GIO_IDX_P8_LATCH: st_d.p8_latch = I_PWDATA[1:0];
        GIO_IDX_P9_LATCH: st_d.p9_latch = I_PWDATA[1:0];
        GIO_IDX_P7_DIR: st_d.p7_dir = I_PWDATA[7:0];
        GIO_IDX_P8_DIR: st_d.p8_dir = I_PWDATA[1:0];
        GIO_IDX_P9_DIR: st_d.p9_dir = I_PWDATA[1:0];
        GIO_IDX_P7_ALT: st_d.p7_alt = I_PWDATA[4:0];
        GIO_IDX_P8_ALT: st_d.p8_alt = I_PWDATA[1:0];
        GIO_IDX_P9_ALT: st_d.p9_alt = I_PWDATA[1:0];
        GIO_IDX_P9_DRIVE: st_d.p9_drive = I_PWDATA[1:0];
        GIO_IDX_P9_PULLUP: st_d.p9_pullup = I_PWDATA[1:0];
        default: st_d.p9_pullup = st_q.p9_pullup;
      endcase
    end

    // one wait state: answer is prepared in the first access cycle
    st_d.pready = rd_phase;
    st_d.pslverr = rd_phase & ~mapped(idx);
    st_d.prdata = GIO_RESET_WORD;
    if (rd_phase) begin
      case (idx)
        GIO_IDX_P7_LATCH: st_d.prdata[7:0] = st_q.p7_latch;
        GIO_IDX_P8_LATCH: st_d.prdata[1:0] = st_q.p8_latch;
        GIO_IDX_P9_LATCH: st_d.prdata[1:0] = st_q.p9_latch;
        GIO_IDX_P7_PIN: st_d.prdata[7:0] = st_q.p7_sync2 & ~st_q.p7_dir;
        GIO_IDX_P8_PIN: st_d.prdata[1:0] = st_q.p8_sync2 & ~st_q.p8_dir;
        GIO_IDX_P9_PIN: st_d.prdata[1:0] = st_q.p9_sync2 & (~st_q.p9_dir | st_q.p9_drive);
        GIO_IDX_P7_DIR: st_d.prdata[7:0] = st_q.p7_dir;
        GIO_IDX_P8_DIR: st_d.prdata[1:0] = st_q.p8_dir;
        GIO_IDX_P9_DIR: st_d.prdata[1:0] = st_q.p9_dir;
        GIO_IDX_P7_ALT: st_d.prdata[4:0] = st_q.p7_alt;
        GIO_IDX_P8_ALT: st_d.prdata[1:0] = st_q.p8_alt;
        GIO_IDX_P9_ALT: st_d.prdata[1:0] = st_q.p9_alt;
        GIO_IDX_P9_DRIVE: st_d.prdata[1:0] = st_q.p9_drive;
        GIO_IDX_P9_PULLUP: st_d.prdata[1:0] = st_q.p9_pullup;
        default: st_d.prdata = GIO_RESET_WORD;
      endcase
    end

    // ****************************************************
    // pad drive
    // ****************************************************
    // peripheral outputs are same-clock logic, taken without sync
    p7_val = st_q.p7_latch;
    p7_val[4:0] = (st_q.p7_alt & I_P7_PERIPH_OUT) | (~st_q.p7_alt & st_q.p7_latch[4:0]);
    p8_val = (st_q.p8_alt & I_P8_PERIPH_OUT) | (~st_q.p8_alt & st_q.p8_latch);
    p9_val = (st_q.p9_alt & {2{I_SECOND_UART_TRANSMIT}}) | (~st_q.p9_alt & st_q.p9_latch);

    st_d.p7_out = p7_val;
    st_d.p7_oe = st_q.p7_dir;
    st_d.p8_out = p8_val;
    st_d.p8_oe = st_q.p8_dir;
    // open-drain only sinks; a high releases the pad to the pull-up
    st_d.p9_out = p9_val & ~st_q.p9_drive;
    st_d.p9_oe = st_q.p9_dir & (~st_q.p9_drive | ~p9_val);
    st_d.p9_pull_on = st_q.p9_pullup & (~st_q.p9_dir | st_q.p9_drive);

    // alternate inputs seen by peripherals only while the pin is an input
    st_d.p7_func_in = st_q.p7_sync2 & ~st_q.p7_dir & GIO_P7_IN_FUNC_MASK;
    st_d.p8_func_in = st_q.p8_sync2 & ~st_q.p8_dir;
    // uart selection lives elsewhere; software must set it too
    st_d.p9_rx_in = st_q.p9_sync2 & ~st_q.p9_dir;
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      st_q <= GIO_STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign O_PREADY = st_q.pready;
  assign O_PRDATA = st_q.prdata;
  assign O_PSLVERR = st_q.pslverr;
  assign O_P7_OUT = st_q.p7_out;
  assign O_P7_OE = st_q.p7_oe;
  assign O_P8_OUT = st_q.p8_out;
  assign O_P8_OE = st_q.p8_oe;
  assign O_P9_OUT = st_q.p9_out;
  assign O_P9_OE = st_q.p9_oe;
  assign O_P9_PULLUP_ON = st_q.p9_pull_on;
  assign O_P7_FUNC_IN = st_q.p7_func_in;
  assign O_P8_FUNC_IN = st_q.p8_func_in;
  assign O_SECOND_UART_RECEIVE = st_q.p9_rx_in;

endmodule

// File: testbench/gio_checker.sv
module gio_checker (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PSLVERR,
  input wire logic [7:0] O_P7_OE,
  input wire logic [1:0] O_P8_OE,
  input wire logic [1:0] O_P9_OUT,
  input wire logic [1:0] O_P9_OE,
  input wire logic [1:0] O_P9_PULLUP_ON,
  input wire logic [7:0] O_P7_FUNC_IN,
  input wire logic [1:0] O_P8_FUNC_IN,
  input wire logic [1:0] O_SECOND_UART_RECEIVE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);
  ready_one_cycle_a: assert property (O_PREADY |=> !O_PREADY) else $error("ready held");
  one_wait_state_a: assert property (I_PSEL && $rose(I_PENABLE) |=> O_PREADY) else $error("late ready");
  ready_caused_a: assert property (O_PREADY |-> $past(I_PSEL && I_PENABLE)) else $error("stray ready");
  idle_data_a: assert property (!O_PREADY |-> O_PRDATA == '0) else $error("idle data");
  err_reads_zero_a: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == '0) else $error("bad err");
  p7_in_or_out_a: assert property ((O_P7_FUNC_IN & O_P7_OE) == '0 && !O_P7_FUNC_IN[4]) else $error("p7");
  p8_in_or_out_a: assert property ((O_P8_FUNC_IN & O_P8_OE) == '0) else $error("p8 input");
  rx_in_only_a: assert property ((O_SECOND_UART_RECEIVE & O_P9_OE) == '0) else $error("rx");
  pull_not_high_a: assert property ((O_P9_PULLUP_ON & O_P9_OE & O_P9_OUT) == '0) else $error("pull");
  reset_idle_a: assert property (disable iff (1'b0) I_RST |=> O_P7_OE == '0 && O_P8_OE == '0
    && O_P9_OE == '0 && O_P9_PULLUP_ON == '0) else $error("reset outputs");
  cover property (O_PREADY && !O_PSLVERR);
  cover property (O_PSLVERR);
  cover property (O_P9_PULLUP_ON != '0);
endmodule

// File: testbench/gio_pad_model.sv
module gio_pad_model (
  input wire logic [11:0] i_oe,
  input wire logic [11:0] i_out,
  input wire logic [11:0] i_ext,
  output logic [11:0] o_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // far side keeps driving where the block lets go, so stale levels never linger
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// File: testbench/test_general_io_ports_seven_eight_nine.sv
module test_general_io_ports_seven_eight_nine;
  timeunit 1ns;
  timeprecision 100ps;
  import gio_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, tx = 1'b0, rdy, err;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h7BB1;
  logic [7:0] p7_out, p7_oe, p7_fin, v[11];
  logic [1:0] p8_out, p8_oe, p9_out, p9_oe, p9_pu, p8_fin, rx, val, drv, dir;
  logic [4:0] p7_per = '0;
  logic [1:0] p8_per = '0;
  logic [11:0] ext = '0, pin;
  logic [33:0] q[$], e;
  int bad_count = 0, num_checks = 0, cyc = 0;
  localparam logic [11:0] IDX[11] = '{GIO_IDX_P7_LATCH, GIO_IDX_P8_LATCH, GIO_IDX_P9_LATCH, GIO_IDX_P7_DIR,
    GIO_IDX_P8_DIR, GIO_IDX_P9_DIR, GIO_IDX_P7_ALT, GIO_IDX_P8_ALT, GIO_IDX_P9_ALT, GIO_IDX_P9_PULLUP, GIO_IDX_P9_DRIVE};
  localparam logic [7:0] MSK[11] = '{8'hFF, 8'h03, 8'h03, 8'hFF, 8'h03, 8'h03, 8'h1F, 8'h03, 8'h03, 8'h03, 8'h03};
  always #12.5 clk = ~clk;
  gio_top u_gio_top (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(rdy), .O_PRDATA(prdata), .O_PSLVERR(err),
    .I_P7_PIN(pin[7:0]), .O_P7_OUT(p7_out), .O_P7_OE(p7_oe), .I_P8_PIN(pin[9:8]), .O_P8_OUT(p8_out),
    .O_P8_OE(p8_oe), .I_P9_PIN(pin[11:10]), .O_P9_OUT(p9_out), .O_P9_OE(p9_oe), .O_P9_PULLUP_ON(p9_pu),
    .I_P7_PERIPH_OUT(p7_per), .I_P8_PERIPH_OUT(p8_per), .I_SECOND_UART_TRANSMIT(tx),
    .O_P7_FUNC_IN(p7_fin), .O_P8_FUNC_IN(p8_fin), .O_SECOND_UART_RECEIVE(rx));
  gio_pad_model u_gio_pad_model (.i_oe({p9_oe, p8_oe, p7_oe}), .i_out({p9_out, p8_out, p7_out}),
    .i_ext(ext), .o_pin(pin));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // expectation is {is_read, slverr, data}
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d, input logic [33:0] x);
    q.push_back(x);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // request stands until pready is seen high at a rising edge
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk_pins();
    @(negedge clk);
    val = (v[8][1:0] & {2{tx}}) | (~v[8][1:0] & v[2][1:0]);
    drv = v[10][1:0];
    dir = v[5][1:0];
    cmp(p7_oe, v[3]);
    cmp(p7_out & v[3], ((v[6] & {3'b0, p7_per}) | (~v[6] & v[0])) & v[3]);
    cmp(p8_oe, v[4]);
    cmp(p8_out & v[4][1:0], ((v[7][1:0] & p8_per) | (~v[7][1:0] & v[1][1:0])) & v[4][1:0]);
    cmp(p9_oe, dir & (~drv | ~val));
    cmp(p9_out & p9_oe, ~drv & val & dir);
    cmp(p9_pu, v[9][1:0] & (~dir | drv));
    cmp(p7_fin, ext[7:0] & ~v[3] & 8'hEF);
    cmp(p8_fin, ext[9:8] & ~v[4][1:0]);
    cmp(rx, pin[11:10] & ~dir);
  endtask
  // answer taken at the same rising edge the master sees pready
  always @(posedge clk) begin
    if (rdy === 1'b1) begin
      e = q.pop_front();
      cmp(err, e[32]);
      if (e[33]) cmp(prdata, e[31:0]);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) xfer(1'b0, IDX[i], '0, {2'b10, 32'h0});
    xfer(1'b1, 12'h100, 32'hFF, {2'b01, 32'h0});
    xfer(1'b0, 12'h100, '0, {2'b11, 32'h0});
    for (int n = 0; n < 40; n++) begin
      r = rnd();
      ext <= r[11:0];
      p7_per <= r[16:12];
      p8_per <= r[18:17];
      tx <= r[19];
      for (int i = 0; i < 11; i++) begin
        r = rnd();
        v[i] = r[7:0] & MSK[i];
        xfer(1'b1, IDX[i], r, '0);
        xfer(1'b0, IDX[i], '0, {2'b10, 24'h0, v[i]});
      end
      repeat (4) @(posedge clk);
      chk_pins();
      xfer(1'b0, GIO_IDX_P7_PIN, '0, {2'b10, 24'h0, ext[7:0] & ~v[3]});
      xfer(1'b0, GIO_IDX_P8_PIN, '0, {2'b10, 30'h0, ext[9:8] & ~v[4][1:0]});
      xfer(1'b0, GIO_IDX_P9_PIN, '0, {2'b10, 30'h0, pin[11:10] & (~dir | drv)});
    end
    // second reset with everything configured: all must clear again
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) xfer(1'b0, IDX[i], '0, {2'b10, 32'h0});
    results();
  end
endmodule
bind gio_top gio_checker u_gio_checker (.*);
